// file: rtl/sys_cfg_bus_if.sv
// Register write carrier between the top and the unlock sequencer
`default_nettype none
interface sys_cfg_bus_if;
   logic       wr_unlock;
   logic [7:0] wdata;
   logic       unlocked;
   logic       unlock_event;
   modport top (output wr_unlock, output wdata, input unlocked, input unlock_event);
   modport seq (input wr_unlock, input wdata, output unlocked, output unlock_event);
endinterface
`default_nettype wire

// file: rtl/sys_cfg_pkg.sv
// Shared constants and types for the system configuration and supply monitor block
`default_nettype none
package sys_cfg_pkg;
   // -----------------------------
   // Register offsets (byte bus)
   // -----------------------------
   localparam logic [3:0] OFF_UNLOCK    = 4'h0;
   localparam logic [3:0] OFF_SEMAPHORE = 4'h1;
   localparam logic [3:0] OFF_ID_HIGH   = 4'h2;
   localparam logic [3:0] OFF_ID_LOW    = 4'h3;
   localparam logic [3:0] OFF_LV_CTRL   = 4'h4;
   localparam logic [3:0] OFF_IRQ_STAT  = 4'h5;
   localparam logic [3:0] OFF_IRQ_MASK  = 4'h6;
   localparam logic [3:0] OFF_FLASH_PROT = 4'h7;
   // -----------------------------
   // Unlock sequence values
   // -----------------------------
   localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2   = 8'hAA;
   localparam int         UNLOCK_BIT    = 0;
   localparam int         PROT_DIS_BIT  = 7;
   // -----------------------------
   // Identification (value arbitrary)
   // -----------------------------
   localparam logic [11:0] PART_ID_DEFAULT = 12'h5A3;
   localparam logic [3:0]  ID_HIGH_PAD     = 4'h0;
   // -----------------------------
   // Low-voltage register fields
   // -----------------------------
   localparam int WARN_FLAG_BIT = 7;
   localparam int WARN_ACK_BIT  = 6;
   localparam int WARN_IE_BIT   = 5;
   localparam int UV_RST_EN_BIT = 4;
   localparam int UV_STOP_BIT   = 3;
   localparam int UV_DET_BIT    = 2;
   localparam logic [7:0] LV_CTRL_RESET = 8'h1C;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   // -----------------------------
   // Interrupt status bits
   // -----------------------------
   localparam int IRQ_WARN_BIT  = 0;
   localparam int IRQ_UV_BIT    = 1;
   localparam int IRQ_UNLK_BIT  = 2;
   localparam int IRQ_BITS      = 3;
   localparam logic [IRQ_BITS-1:0] IRQ_ZERO = 3'h0;
   // -----------------------------
   // Unlock sequencer states
   // -----------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_KEY1 = 2'b10
   } unlock_state_t;
endpackage
`default_nettype wire

// file: rtl/system_config_lvd_regs.sv
// System configuration registers: unlock, boot semaphore, part id, supply monitor
//
// Contract
// - Unlock bit sets only after writes 0x55 then 0xAA back to back.
// - Any other write to the unlock register clears the unlock bit.
// - Flash protect disable can be set only while unlock bit reads 1.
// - Boot semaphore clears only on power-on reset, kept across others.
// - Boot semaphore byte is readable after a regular reset.
// - Writes to upper nibble of id high are ignored.
// - Hard-wired 12-bit part id split over id high and id low.
// - Reset enable and detect enable accept only the first write after reset.
// - Warning flag sets when supply is below warning trip point.
// - Acknowledge clears warning flag only if warning has gone.
// - Interrupt request while warning flag and its enable are both 1.
// - Undervoltage event forces reset when reset and detect enables are 1.
// - Stop enable keeps detection running in stop mode when detect enabled.
// - Detect enable gates detect logic and qualifies reset and stop enables.
`default_nettype none
module system_config_lvd_regs
#(
   parameter logic [11:0] PART_ID = sys_cfg_pkg::PART_ID_DEFAULT
)(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       por_b,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       supply_warning,
   input  wire logic       undervoltage_detect,
   input  wire logic       stop_mode,
   output logic            undervoltage_reset,
   output logic            undervoltage_monitor_on,
   output logic            flash_protect_disable,
   output logic            irq
);
   import sys_cfg_pkg::*;

   // -----------------------------
   // Register state and internal nets
   // -----------------------------
   sys_cfg_bus_if bus ();

   logic [7:0]          boot_semaphore;
   logic                supply_warning_flag;
   logic                supply_warning_irq_enable;
   logic                undervoltage_reset_enable;
   logic                undervoltage_stop_enable;
   logic                undervoltage_detect_enable;
   logic                once_written;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_mask;
   logic [IRQ_BITS-1:0] irq_events;
   logic [7:0]          next_rdata;
   logic [7:0]          lv_ctrl_view;
   logic                detect_active;
   logic                uv_event;
   logic [7:0]          unlock_view;
   logic [7:0]          prot_view;
   logic [7:0]          irq_stat_view;
   logic [7:0]          irq_mask_view;
   logic [7:0]          id_high_view;
   logic [7:0]          id_low_view;

   // -----------------------------
   // Write decode
   // -----------------------------
   logic wr_unlock;
   logic wr_sem;
   logic wr_lv;
   logic wr_stat;
   logic wr_mask;
   logic wr_prot;

   always_comb begin
      wr_unlock = 1'b0;
      wr_sem    = 1'b0;
      wr_lv     = 1'b0;
      wr_stat   = 1'b0;
      wr_mask   = 1'b0;
      wr_prot   = 1'b0;
      if (wr && addr == OFF_UNLOCK) begin
         wr_unlock = 1'b1;
      end else if (wr && addr == OFF_SEMAPHORE) begin
         wr_sem = 1'b1;
      end else if (wr && addr == OFF_LV_CTRL) begin
         wr_lv = 1'b1;
      end else if (wr && addr == OFF_IRQ_STAT) begin
         wr_stat = 1'b1;
      end else if (wr && addr == OFF_IRQ_MASK) begin
         wr_mask = 1'b1;
      end else if (wr && addr == OFF_FLASH_PROT) begin
         wr_prot = 1'b1;
      end
   end

   // -----------------------------
   // Unlock sequencer
   // -----------------------------
   // Only unlock-register writes reach the sequencer, other offsets never break it
   assign bus.wr_unlock = wr_unlock;
   assign bus.wdata     = wdata;

   unlock_sequencer u_seq (
      .clk   (clk),
      .rst_b (rst_b),
      .bus   (bus)
   );

   // -----------------------------
   // Flash protection disable
   // -----------------------------
   // set only while unlocked
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flash_protect_disable <= 1'b0;
      end else if (wr_prot) begin
         if (!wdata[PROT_DIS_BIT]) begin
            flash_protect_disable <= 1'b0;
         end else if (bus.unlocked) begin
            flash_protect_disable <= 1'b1;
         end
      end
   end

   // -----------------------------
   // Boot semaphore
   // -----------------------------
   // only power-on reset clears
   // Regular reset is deliberately ignored so the bootloader decision survives
   always_ff @(posedge clk) begin
      if (!por_b) begin
         boot_semaphore <= BYTE_ZERO;
      end else if (wr_sem) begin
         boot_semaphore <= wdata;
      end
   end

   // -----------------------------
   // Supply monitor control
   // -----------------------------
   // write-once reset and detect enables
   // Any first write locks both enables, even one that repeats the reset values
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         once_written <= 1'b0;
      end else if (wr_lv) begin
         once_written <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         undervoltage_reset_enable <= LV_CTRL_RESET[UV_RST_EN_BIT];
      end else if (wr_lv && !once_written) begin
         undervoltage_reset_enable <= wdata[UV_RST_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         undervoltage_detect_enable <= LV_CTRL_RESET[UV_DET_BIT];
      end else if (wr_lv && !once_written) begin
         undervoltage_detect_enable <= wdata[UV_DET_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         supply_warning_irq_enable <= LV_CTRL_RESET[WARN_IE_BIT];
      end else if (wr_lv) begin
         supply_warning_irq_enable <= wdata[WARN_IE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         undervoltage_stop_enable <= LV_CTRL_RESET[UV_STOP_BIT];
      end else if (wr_lv) begin
         undervoltage_stop_enable <= wdata[UV_STOP_BIT];
      end
   end

   // -----------------------------
   // Undervoltage detect and reset
   // -----------------------------
   // detect enable gates logic
   assign detect_active = undervoltage_detect_enable
                          && (!stop_mode || undervoltage_stop_enable);
   assign undervoltage_monitor_on = detect_active;
   assign uv_event = detect_active && undervoltage_detect;

   // forced reset on detect
   // Registered so a glitch on the detect input never reaches the reset tree directly
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         undervoltage_reset <= 1'b0;
      end else begin
         undervoltage_reset <= uv_event && undervoltage_reset_enable;
      end
   end

   // -----------------------------
   // Warning flag
   // -----------------------------
   // set while below trip
   // ack clears once warning gone
   // Set wins over acknowledge, so a live warning can never be lost
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         supply_warning_flag <= 1'b0;
      end else if (supply_warning) begin
         supply_warning_flag <= 1'b1;
      end else if (wr_lv && wdata[WARN_ACK_BIT]) begin
         supply_warning_flag <= 1'b0;
      end
   end

   // -----------------------------
   // Interrupt status and mask
   // -----------------------------
   // Warning event marks the flag's rising edge only, not every cycle of a brown-out
   assign irq_events[IRQ_WARN_BIT] = supply_warning && !supply_warning_flag;
   assign irq_events[IRQ_UV_BIT]   = uv_event;
   assign irq_events[IRQ_UNLK_BIT] = bus.unlock_event;

   generate
      for (genvar i = 0; i < IRQ_BITS; i++) begin : g_stat
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               irq_status[i] <= 1'b0;
            end else if (irq_events[i]) begin
               irq_status[i] <= 1'b1;
            end else if (wr_stat && wdata[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_mask <= IRQ_ZERO;
      end else if (wr_mask) begin
         irq_mask <= wdata[IRQ_BITS-1:0];
      end
   end

   // -----------------------------
   // Interrupt output
   // -----------------------------
   // warning flag with enable, or any status bit set under its mask
   assign irq = (supply_warning_flag && supply_warning_irq_enable)
                || |(irq_status & irq_mask);

   // -----------------------------
   // Read path
   // -----------------------------
   // ack and low bits read 0
   always_comb begin
      lv_ctrl_view                = BYTE_ZERO;
      lv_ctrl_view[WARN_FLAG_BIT] = supply_warning_flag;
      lv_ctrl_view[WARN_IE_BIT]   = supply_warning_irq_enable;
      lv_ctrl_view[UV_RST_EN_BIT] = undervoltage_reset_enable;
      lv_ctrl_view[UV_STOP_BIT]   = undervoltage_stop_enable;
      lv_ctrl_view[UV_DET_BIT]    = undervoltage_detect_enable;
   end

   always_comb begin
      unlock_view             = BYTE_ZERO;
      unlock_view[UNLOCK_BIT] = bus.unlocked;
   end

   always_comb begin
      prot_view               = BYTE_ZERO;
      prot_view[PROT_DIS_BIT] = flash_protect_disable;
   end

   always_comb begin
      irq_stat_view               = BYTE_ZERO;
      irq_stat_view[IRQ_BITS-1:0] = irq_status;
   end

   always_comb begin
      irq_mask_view               = BYTE_ZERO;
      irq_mask_view[IRQ_BITS-1:0] = irq_mask;
   end

   // hard-wired part id
   // A fixed pad costs nothing, and software must not rely on those bits anyway
   assign id_high_view = {ID_HIGH_PAD, PART_ID[11:8]};
   assign id_low_view  = PART_ID[7:0];

   // Unmapped offsets fall through to zero
   always_comb begin
      next_rdata = BYTE_ZERO;
      if (addr == OFF_UNLOCK) begin
         next_rdata = unlock_view;
      end else if (addr == OFF_SEMAPHORE) begin
         next_rdata = boot_semaphore;
      end else if (addr == OFF_ID_HIGH) begin
         next_rdata = id_high_view;
      end else if (addr == OFF_ID_LOW) begin
         next_rdata = id_low_view;
      end else if (addr == OFF_LV_CTRL) begin
         next_rdata = lv_ctrl_view;
      end else if (addr == OFF_IRQ_STAT) begin
         next_rdata = irq_stat_view;
      end else if (addr == OFF_IRQ_MASK) begin
         next_rdata = irq_mask_view;
      end else if (addr == OFF_FLASH_PROT) begin
         next_rdata = prot_view;
      end
   end

   // -----------------------------
   // Read data register
   // -----------------------------
   // Read data holds one cycle only, zero otherwise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= BYTE_ZERO;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= BYTE_ZERO;
      end
   end
endmodule // system_config_lvd_regs
`default_nettype wire

// file: rtl/unlock_sequencer.sv
// Two-write unlock sequencer that arms the flash protection disable
`default_nettype none
module unlock_sequencer
(
   input  wire logic clk,
   input  wire logic rst_b,
   sys_cfg_bus_if.seq bus
);
   import sys_cfg_pkg::*;

   unlock_state_t state;
   logic          unlocked_q;

   // -----------------------------
   // Sequence tracking
   // -----------------------------
   // broken sequence restarts
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= SEQ_IDLE;
      end else if (bus.wr_unlock) begin
         if (bus.wdata == UNLOCK_KEY1) begin
            state <= SEQ_KEY1;
         end else begin
            state <= SEQ_IDLE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         unlocked_q <= 1'b0;
      end else if (bus.wr_unlock) begin
         unlocked_q <= (state == SEQ_KEY1) && (bus.wdata == UNLOCK_KEY2);
      end
   end

   assign bus.unlocked     = unlocked_q;
   assign bus.unlock_event = bus.wr_unlock && (state == SEQ_KEY1)
                             && (bus.wdata == UNLOCK_KEY2);
endmodule // unlock_sequencer
`default_nettype wire

// file: tb/system_config_lvd_regs_props.sv
// Assertion checker for the system config register ports
`default_nettype none
module sys_cfg_props
#(
   parameter logic [11:0] PART_ID = sys_cfg_pkg::PART_ID_DEFAULT
)(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       undervoltage_detect,
   input wire logic       stop_mode,
   input wire logic       undervoltage_reset,
   input wire logic       undervoltage_monitor_on,
   input wire logic       flash_protect_disable
);
   import sys_cfg_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   uv_cause_a:
   assert property (undervoltage_reset |-> $past(undervoltage_detect))
      else $error("reset without detect event");
   uv_gate_a:
   assert property (undervoltage_reset |-> $past(undervoltage_monitor_on))
      else $error("reset while monitor off");
   fpd_set_a:
   assert property ($rose(flash_protect_disable) |-> $past(wr)
      && $past(addr) == OFF_FLASH_PROT && $past(wdata[PROT_DIS_BIT]))
      else $error("protect disable set without write");
   fpd_fall_a:
   assert property ($fell(flash_protect_disable) |-> !$past(rst_b)
      || ($past(wr) && $past(addr) == OFF_FLASH_PROT))
      else $error("protect disable lost without cause");
   id_low_a:
   assert property ($past(rd) && $past(addr) == OFF_ID_LOW |-> rdata == PART_ID[7:0])
      else $error("id low wrong");
   id_high_a:
   assert property ($past(rd) && $past(addr) == OFF_ID_HIGH |-> rdata[3:0] == PART_ID[11:8])
      else $error("id high wrong");
   lv_zero_a:
   assert property ($past(rd) && $past(addr) == OFF_LV_CTRL
      |-> rdata[6] == 1'h0 && rdata[1:0] == 2'h0)
      else $error("unimplemented bits not zero");
   mon_hold_a:
   assert property ($past(rst_b) && !$past(wr) && $stable(stop_mode)
      |-> $stable(undervoltage_monitor_on))
      else $error("monitor changed without cause");
endmodule // sys_cfg_props
bind system_config_lvd_regs sys_cfg_props #(.PART_ID(PART_ID)) props_u (
   .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .undervoltage_detect(undervoltage_detect), .stop_mode(stop_mode),
   .undervoltage_reset(undervoltage_reset),
   .undervoltage_monitor_on(undervoltage_monitor_on),
   .flash_protect_disable(flash_protect_disable));
`default_nettype wire

// file: tb/system_config_lvd_regs_tb.sv
// Self-checking bench for the system config registers
`default_nettype none
module system_config_lvd_regs_tb
   import sys_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary part code
   localparam logic [11:0] PID = 12'h3C7;
   logic       clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
   logic       warn = 1'b0, uvd = 1'b0, stop = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, s;
   logic       uv_rst, mon, fpd, irq;
   logic [7:0] exp_q[$], msk_q[$];
   string      nam_q[$];
   int         n_mismatch = 0, cmp_count = 0;
   always #2 clk = ~clk;
   system_config_lvd_regs #(.PART_ID(PID)) dut_u (.clk(clk), .rst_b(rst_b), .por_b(por_b),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .supply_warning(warn),
      .undervoltage_detect(uvd), .stop_mode(stop), .undervoltage_reset(uv_rst),
      .undervoltage_monitor_on(mon), .flash_protect_disable(fpd), .irq(irq));
   task automatic check(input string n, input logic [7:0] seen, input logic [7:0] e);
      cmp_count++;
      if (seen !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, seen);
      end
   endtask
   // Strobes stay up so writes can run back to back; idle lowers them
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      rd    <= 1'b0;
   endtask
   task automatic rd_reg(input string n, input logic [3:0] a, input logic [7:0] e,
                         input logic [7:0] m);
      @(posedge clk);
      addr <= a;
      wr   <= 1'b0;
      rd   <= 1'b1;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      nam_q.push_back(n);
   endtask
   task automatic idle(input int n);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic reset(input logic p);
      @(posedge clk);
      rst_b <= 1'b0;
      por_b <= ~p;
      uvd   <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Read data counts only in the cycle after the strobe
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd_q) check(nam_q.pop_front(), rdata & msk_q.pop_front(), exp_q.pop_front());
   end
   initial begin
      #5000;
      n_mismatch++;
      print_verdict;
   end
   initial begin
      void'($urandom(32'h5DCCB701));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      rd_reg("lv_ctrl", OFF_LV_CTRL, LV_CTRL_RESET, 8'hFF);
      wr_reg(OFF_ID_HIGH, 8'hFF);
      rd_reg("id_high", OFF_ID_HIGH, {4'h0, PID[11:8]}, 8'h0F);
      rd_reg("id_low", OFF_ID_LOW, PID[7:0], 8'hFF);
      rd_reg("unmapped", {1'b1, 3'($urandom)}, 8'h00, 8'hFF);
      wr_reg(OFF_FLASH_PROT, 8'h80);
      idle(1);
      #1 check("fpd_locked", 8'(fpd), 8'h00);
      $display("test reset values done");
      wr_reg(OFF_UNLOCK, UNLOCK_KEY1);
      wr_reg(OFF_UNLOCK, UNLOCK_KEY2);
      rd_reg("unlock", OFF_UNLOCK, 8'h01, 8'h01);
      rd_reg("irq_unlk", OFF_IRQ_STAT, 8'h04, 8'h04);
      wr_reg(OFF_FLASH_PROT, 8'h80);
      idle(1);
      #1 check("fpd_open", 8'(fpd), 8'h01);
      wr_reg(OFF_UNLOCK, 8'h12);
      rd_reg("unlock_cleared", OFF_UNLOCK, 8'h00, 8'h01);
      s = 8'($urandom);
      if (s == UNLOCK_KEY1 || s == UNLOCK_KEY2) s = 8'h3C;
      wr_reg(OFF_FLASH_PROT, 8'h00);
      wr_reg(OFF_UNLOCK, UNLOCK_KEY1);
      wr_reg(OFF_UNLOCK, s);
      wr_reg(OFF_UNLOCK, UNLOCK_KEY2);
      rd_reg("unlock_broken", OFF_UNLOCK, 8'h00, 8'h01);
      wr_reg(OFF_FLASH_PROT, 8'h80);
      idle(1);
      #1 check("fpd_relocked", 8'(fpd), 8'h00);
      $display("test unlock done");
      s = 8'($urandom);
      wr_reg(OFF_SEMAPHORE, s);
      idle(0);
      reset(1'b0);
      rd_reg("sem_kept", OFF_SEMAPHORE, s, 8'hFF);
      idle(0);
      reset(1'b1);
      rd_reg("sem_por", OFF_SEMAPHORE, 8'h00, 8'hFF);
      wr_reg(OFF_LV_CTRL, 8'h00);
      wr_reg(OFF_LV_CTRL, 8'h3C);
      rd_reg("lv_once", OFF_LV_CTRL, 8'h28, 8'hFF);
      idle(0);
      uvd <= 1'b1;
      idle(2);
      #1 check("mon_off", 8'(mon), 8'h00);
      check("uv_no_det", 8'(uv_rst), 8'h00);
      $display("test semaphore and write once done");
      reset(1'b0);
      wr_reg(OFF_LV_CTRL, 8'h14);
      stop <= 1'b1;
      uvd  <= 1'b1;
      idle(2);
      #1 check("mon_stop", 8'(mon), 8'h00);
      check("uv_stop", 8'(uv_rst), 8'h00);
      @(posedge clk) stop <= 1'b0;
      idle(1);
      #1 check("uv_reset", 8'(uv_rst), 8'h01);
      wr_reg(OFF_LV_CTRL, 8'h08);
      stop <= 1'b1;
      uvd  <= 1'b0;
      rd_reg("lv_stop_en", OFF_LV_CTRL, 8'h1C, 8'hFF);
      idle(1);
      #1 check("mon_stop_en", 8'(mon), 8'h01);
      $display("test detect done");
      @(posedge clk) warn <= 1'b1;
      idle(2);
      rd_reg("lv_flag", OFF_LV_CTRL, 8'h9C, 8'hFF);
      rd_reg("irq_stat", OFF_IRQ_STAT, 8'h03, 8'h07);
      idle(1);
      #1 check("irq_polled", 8'(irq), 8'h00);
      wr_reg(OFF_IRQ_MASK, 8'h01);
      idle(1);
      #1 check("irq_masked_in", 8'(irq), 8'h01);
      wr_reg(OFF_IRQ_STAT, 8'h07);
      idle(1);
      #1 check("irq_w1c", 8'(irq), 8'h00);
      wr_reg(OFF_LV_CTRL, 8'h28);
      idle(1);
      #1 check("irq_enabled", 8'(irq), 8'h01);
      wr_reg(OFF_LV_CTRL, 8'h68);
      rd_reg("ack_held", OFF_LV_CTRL, 8'hBC, 8'hFF);
      idle(0);
      warn <= 1'b0;
      wr_reg(OFF_LV_CTRL, 8'h68);
      rd_reg("ack_clear", OFF_LV_CTRL, 8'h3C, 8'hFF);
      idle(1);
      #1 check("irq_gone", 8'(irq), 8'h00);
      $display("test warning done");
      print_verdict;
   end
endmodule // system_config_lvd_regs_tb
`default_nettype wire
